// ==== esrc_ctrl.sv ====
`timescale 1ns/1ps
`include "esrc_regs.svh"
// What this block does
// - Opcode 75h pauses a running sector, 32KB or 64KB erase into suspend.
// - While suspended, reads and programs avoid only the paused erase region.
// - Only erases suspend; a status write or program cycle is never paused.
// - After the suspend latency, write latch clears and erase-suspended sets.
// - After latency, reads, IDs, wrap, programs, write latch and resume are accepted.
// - Status reads and reset opcodes are accepted at once after a suspend.
// - Status bit 15 reports the erase-suspended flag.
// - Resume acts only when suspended and not busy; otherwise it is ignored.
// - Accepted resume clears suspended at once, raises busy within 200 ns, finishes erase.
// - Busy reads 1 during any self-timed program or erase, 0 after.
module esrc_ctrl #(
   parameter int unsigned SE_CYC   = `ESRC_SE_MS * 1000 * `ESRC_CLK_MHZ,
   parameter int unsigned BE32_CYC = `ESRC_BE32_MS * 1000 * `ESRC_CLK_MHZ,
   parameter int unsigned BE64_CYC = `ESRC_BE64_MS * 1000 * `ESRC_CLK_MHZ,
   parameter int unsigned PP_CYC   = `ESRC_PP_US * `ESRC_CLK_MHZ
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              cs_n,
   input  wire logic              sclk,
   input  wire logic              si,
   output logic                   so,
   output logic                   so_oe_n,
   output esrc_pkg::esrc_cmd_t    cmd,
   output logic                   cmd_valid,
   output logic                   cmd_reject,
   output logic                   busy_cycle_flag,
   output logic                   write_latch_flag,
   output logic                   erase_suspended_flag
);
   localparam int unsigned CNT_MAX = 32'h00ff_ffff;

   if (SE_CYC == 0 || BE32_CYC == 0 || BE64_CYC == 0 || PP_CYC == 0 ||
       SE_CYC > CNT_MAX || BE32_CYC > CNT_MAX || BE64_CYC > CNT_MAX || PP_CYC > CNT_MAX)
   begin : g_bad_param
      $error("cycle counts must lie in 1 to 2^24-1");
   end

   logic [2:0]  cs_s_q;
   logic [2:0]  ck_s_q;
   logic [1:0]  si_s_q;
   logic        ck_rise;
   logic        ck_fall;
   logic        cs_rise;
   logic        cs_low;
   logic [5:0]  bits_q;
   logic [31:0] sh_q;
   logic [7:0]  op_q;
   logic [23:0] addr_q;
   logic [7:0]  out_q;
   logic        drive_q;
   esrc_pkg::esrc_state_t state_q;
   logic [23:0] erase_cnt_q;
   logic [9:0]  lat_q;
   logic [23:0] reg_base_q;
   logic [23:0] reg_mask_q;
   logic [23:0] prog_cnt_q;
   logic        prog_busy_q;
   logic        wel_q;
   logic        rst_en_q;
   logic [15:0] status;
   logic        is_late;
   logic        is_any;
   logic        allowed;
   logic        in_region;
   logic        exec;
   logic        do_erase;
   logic        do_prog;
   logic        do_susp;
   logic        do_resume;
   logic        do_reset;
   logic        do_read;

   // Two flops before any logic; the third stage only serves edge detection
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cs_s_q <= 3'h7;
         ck_s_q <= 3'h0;
         si_s_q <= 2'h0;
      end
      else
      begin
         cs_s_q <= {cs_s_q[1:0], cs_n};
         ck_s_q <= {ck_s_q[1:0], sclk};
         si_s_q <= {si_s_q[0], si};
      end
   end

   assign cs_low  = ~cs_s_q[1];
   assign ck_rise = cs_low & ck_s_q[1] & ~ck_s_q[2];
   assign ck_fall = cs_low & ~ck_s_q[1] & ck_s_q[2];
   assign cs_rise = cs_s_q[1] & ~cs_s_q[2];
   assign exec    = cs_rise & (bits_q >= `ESRC_LEN_OP);

   assign status = {erase_suspended_flag, 13'h0000, wel_q, busy_cycle_flag};

   // Frame shifter; opcode after 8 bits, address after 32
   always_ff @(posedge mclk)
   begin
      if (rst || cs_s_q[1])
      begin
         bits_q <= 6'd0;
         sh_q   <= 32'h0000_0000;
         out_q  <= 8'h00;
         drive_q <= 1'b0;
         if (rst)
         begin
            op_q   <= 8'h00;
            addr_q <= 24'h00_0000;
            so     <= 1'b0;
         end
      end
      else
      begin
         if (ck_rise)
         begin
            sh_q <= {sh_q[30:0], si_s_q[1]};
            if (bits_q != 6'd63)
               bits_q <= bits_q + 6'd1;
            if (bits_q == 6'd7)
            begin
               op_q <= {sh_q[6:0], si_s_q[1]};
               case ({sh_q[6:0], si_s_q[1]})
                  `ESRC_OP_RDSR1: out_q <= status[7:0];
                  `ESRC_OP_RDSR2: out_q <= status[15:8];
                  default:        out_q <= 8'h00;
               endcase
            end
            if (bits_q == 6'd31)
               addr_q <= {sh_q[22:0], si_s_q[1]};
         end
         if (ck_fall && bits_q >= `ESRC_LEN_OP)
         begin
            drive_q <= (op_q == `ESRC_OP_RDSR1) || (op_q == `ESRC_OP_RDSR2) ||
                       (op_q == `ESRC_OP_RDSR3);
            so      <= out_q[7];
            out_q   <= {out_q[6:0], 1'b0};
         end
      end
   end

   assign so_oe_n = ~drive_q;

   always_comb
   begin
      is_any = 1'b0;
      is_late = 1'b0;
      case (op_q)
         `ESRC_OP_RDSR1, `ESRC_OP_RDSR2, `ESRC_OP_RDSR3,
         `ESRC_OP_RSTEN, `ESRC_OP_RST: is_any = 1'b1;
         `ESRC_OP_WREN, `ESRC_OP_WRDI, `ESRC_OP_READ, `ESRC_OP_FREAD, `ESRC_OP_DOR,
         `ESRC_OP_QOR, `ESRC_OP_DIOR, `ESRC_OP_QIOR, `ESRC_OP_QWR, `ESRC_OP_WRAP,
         `ESRC_OP_MID, `ESRC_OP_MID2, `ESRC_OP_MID4, `ESRC_OP_JID, `ESRC_OP_UID,
         `ESRC_OP_RPD, `ESRC_OP_SECR, `ESRC_OP_PARAM, `ESRC_OP_PP, `ESRC_OP_QPP,
         `ESRC_OP_RESUME: is_late = 1'b1;
         default: ;
      endcase
   end

   always_comb
   begin
      case (state_q)
         esrc_pkg::st_susp_wait: allowed = is_any;
         esrc_pkg::st_susp:      allowed = is_any | is_late;
         default:                allowed = 1'b1;
      endcase
   end

   // Region test is only meaningful while an erase is parked
   assign in_region = erase_suspended_flag &&
                      ((addr_q & reg_mask_q) == (reg_base_q & reg_mask_q));
   assign do_reset  = exec && allowed && op_q == `ESRC_OP_RST && rst_en_q;
   assign do_erase  = exec && state_q == esrc_pkg::st_idle && wel_q && !prog_busy_q &&
                      bits_q == `ESRC_LEN_ADDR &&
                      (op_q == `ESRC_OP_SE || op_q == `ESRC_OP_BE32 || op_q == `ESRC_OP_BE64);
   assign do_prog   = exec && allowed && wel_q && !busy_cycle_flag && bits_q >= `ESRC_LEN_DATA &&
                      (op_q == `ESRC_OP_PP || op_q == `ESRC_OP_QPP) && !in_region;
   // Program and status-write cycles never take this path
   assign do_susp   = exec && op_q == `ESRC_OP_SUSPEND && state_q == esrc_pkg::st_erase;
   assign do_resume = exec && op_q == `ESRC_OP_RESUME &&
                      erase_suspended_flag && !busy_cycle_flag;
   assign do_read   = exec && allowed && is_late && !in_region &&
                      op_q != `ESRC_OP_WREN && op_q != `ESRC_OP_WRDI &&
                      op_q != `ESRC_OP_RESUME && op_q != `ESRC_OP_PP && op_q != `ESRC_OP_QPP &&
                      (state_q == esrc_pkg::st_idle || state_q == esrc_pkg::st_susp);

   // Erase sequencer; the remaining count is frozen across a suspend
   always_ff @(posedge mclk)
   begin
      if (rst || do_reset)
      begin
         state_q     <= esrc_pkg::st_idle;
         erase_cnt_q <= 24'h00_0000;
         lat_q       <= 10'd0;
         reg_base_q  <= 24'h00_0000;
         reg_mask_q  <= `ESRC_MASK_4K;
      end
      else
      begin
         case (state_q)
            esrc_pkg::st_idle:
               if (do_erase)
               begin
                  state_q    <= esrc_pkg::st_erase;
                  reg_base_q <= addr_q;
                  case (op_q)
                     `ESRC_OP_SE:
                     begin
                        erase_cnt_q <= SE_CYC[23:0];
                        reg_mask_q  <= `ESRC_MASK_4K;
                     end
                     `ESRC_OP_BE32:
                     begin
                        erase_cnt_q <= BE32_CYC[23:0];
                        reg_mask_q  <= `ESRC_MASK_32K;
                     end
                     default:
                     begin
                        erase_cnt_q <= BE64_CYC[23:0];
                        reg_mask_q  <= `ESRC_MASK_64K;
                     end
                  endcase
               end
            esrc_pkg::st_erase:
               if (do_susp)
               begin
                  state_q <= esrc_pkg::st_susp_wait;
                  lat_q   <= 10'(`ESRC_ESL_CYC);
               end
               else if (erase_cnt_q <= 24'h00_0001)
                  state_q <= esrc_pkg::st_idle;
               else
                  erase_cnt_q <= erase_cnt_q - 24'h00_0001;
            esrc_pkg::st_susp_wait:
               if (lat_q <= 10'd1)
                  state_q <= esrc_pkg::st_susp;
               else
                  lat_q <= lat_q - 10'd1;
            esrc_pkg::st_susp:
               if (do_resume)
                  state_q <= esrc_pkg::st_erase;
            default:
               state_q <= esrc_pkg::st_idle;
         endcase
      end
   end

   // Program cycle, also legal while an erase is parked
   always_ff @(posedge mclk)
   begin
      if (rst || do_reset)
      begin
         prog_busy_q <= 1'b0;
         prog_cnt_q  <= 24'h00_0000;
      end
      else if (do_prog)
      begin
         prog_busy_q <= 1'b1;
         prog_cnt_q  <= PP_CYC[23:0];
      end
      else if (prog_busy_q)
      begin
         if (prog_cnt_q <= 24'h00_0001)
            prog_busy_q <= 1'b0;
         prog_cnt_q <= prog_cnt_q - 24'h00_0001;
      end
   end

   // Write latch: set by enable, cleared by disable, by starting a cycle or by suspend entry
   always_ff @(posedge mclk)
   begin
      if (rst || do_reset)
         wel_q <= 1'b0;
      else if (exec && allowed && op_q == `ESRC_OP_WREN && (!busy_cycle_flag ||
               state_q == esrc_pkg::st_susp))
         wel_q <= 1'b1;
      else if ((exec && allowed && op_q == `ESRC_OP_WRDI) || do_erase || do_prog ||
               (state_q == esrc_pkg::st_susp_wait && lat_q <= 10'd1))
         wel_q <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (rst || do_reset)
         rst_en_q <= 1'b0;
      else if (exec && allowed)
         rst_en_q <= (op_q == `ESRC_OP_RSTEN);
   end

   // Accepted array commands go to the core; rejected ones are flagged only while suspended
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cmd        <= '0;
         cmd_valid  <= 1'b0;
         cmd_reject <= 1'b0;
      end
      else
      begin
         cmd_valid  <= do_read || do_prog;
         cmd_reject <= exec && erase_suspended_flag && !do_read && !do_prog && !do_resume &&
                       !(allowed && (op_q == `ESRC_OP_WREN || op_q == `ESRC_OP_WRDI ||
                       is_any));
         if (do_read || do_prog)
            cmd <= '{opcode: op_q, addr: addr_q};
      end
   end

   assign busy_cycle_flag = prog_busy_q || state_q == esrc_pkg::st_erase ||
                            state_q == esrc_pkg::st_susp_wait;
   assign erase_suspended_flag = (state_q == esrc_pkg::st_susp);
   assign write_latch_flag = wel_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_susp_req;
      do_susp;
   endsequence
   sequence s_latency;
      !erase_suspended_flag [*8];
   endsequence

   susp_latency_a: assert property (s_susp_req |=> s_latency)
      else $error("suspended flag rose before the latency");
   // A soft reset may legally cut the latency short
   susp_entry_a: assert property (disable iff (rst || do_reset)
                                  s_susp_req |-> ##[750:751] erase_suspended_flag)
      else $error("suspend not entered after latency");
   wel_clear_a: assert property ($rose(erase_suspended_flag) |-> !write_latch_flag)
      else $error("write latch still set on suspend entry");
   only_erase_a: assert property (exec && op_q == `ESRC_OP_SUSPEND &&
                                  state_q == esrc_pkg::st_idle |=> state_q == esrc_pkg::st_idle)
      else $error("suspend taken outside an erase");
   resume_gate_a: assert property (exec && op_q == `ESRC_OP_RESUME &&
                                   (!erase_suspended_flag || busy_cycle_flag) |=>
                                   $stable(state_q))
      else $error("resume acted in wrong state");
   resume_act_a: assert property (do_resume |=> !erase_suspended_flag && busy_cycle_flag)
      else $error("resume did not clear suspend and raise busy");
   region_block_a: assert property (exec && in_region |=> !cmd_valid)
      else $error("access into paused region passed");
   early_block_a: assert property (exec && state_q == esrc_pkg::st_susp_wait &&
                                   !is_any |=> !cmd_valid)
      else $error("command taken during suspend latency");
   late_accept_a: assert property (exec && state_q == esrc_pkg::st_susp &&
                                   !in_region && op_q == `ESRC_OP_READ |=> cmd_valid)
      else $error("read refused while suspended");
   susp_idle_a: assert property (erase_suspended_flag && !prog_busy_q |-> !busy_cycle_flag)
      else $error("busy set while parked");
   sr_bit_a: assert property (ck_rise && bits_q == 6'd7 &&
                              {sh_q[6:0], si_s_q[1]} == `ESRC_OP_RDSR2 |=>
                              out_q[7] == $past(erase_suspended_flag))
      else $error("status bit 15 loaded wrongly");
   prog_busy_a: assert property ($rose(prog_busy_q) |-> busy_cycle_flag [*4])
      else $error("busy dropped during program");
endmodule : esrc_ctrl

// ==== esrc_regs.svh ====
`ifndef ESRC_REGS_SVH
`define ESRC_REGS_SVH
// Opcodes
`define ESRC_OP_WREN     8'h06
`define ESRC_OP_WRDI     8'h04
`define ESRC_OP_READ     8'h03
`define ESRC_OP_FREAD    8'h0b
`define ESRC_OP_DOR      8'h3b
`define ESRC_OP_QOR      8'h6b
`define ESRC_OP_DIOR     8'hbb
`define ESRC_OP_QIOR     8'heb
`define ESRC_OP_QWR      8'he7
`define ESRC_OP_WRAP     8'h77
`define ESRC_OP_MID      8'h90
`define ESRC_OP_MID2     8'h92
`define ESRC_OP_MID4     8'h94
`define ESRC_OP_JID      8'h9f
`define ESRC_OP_UID      8'h4b
`define ESRC_OP_RPD      8'hab
`define ESRC_OP_SECR     8'h48
`define ESRC_OP_PARAM    8'h5a
`define ESRC_OP_PP       8'h02
`define ESRC_OP_QPP      8'h32
`define ESRC_OP_RESUME   8'h7a
`define ESRC_OP_SUSPEND  8'h75
`define ESRC_OP_RDSR1    8'h05
`define ESRC_OP_RDSR2    8'h35
`define ESRC_OP_RDSR3    8'h15
`define ESRC_OP_RSTEN    8'h66
`define ESRC_OP_RST      8'h99
`define ESRC_OP_SE       8'h20
`define ESRC_OP_BE32     8'h52
`define ESRC_OP_BE64     8'hd8
// Region masks of the three erase sizes
`define ESRC_MASK_4K     24'hff_f000
`define ESRC_MASK_32K    24'hff_8000
`define ESRC_MASK_64K    24'hff_0000
// Status word bit positions
`define ESRC_SR_BUSY_BIT 0
`define ESRC_SR_WEL_BIT  1
`define ESRC_SR_SUS_BIT  15
// Frame lengths in bits
`define ESRC_LEN_OP      6'd8
`define ESRC_LEN_ADDR    6'd32
`define ESRC_LEN_DATA    6'd40
// Timing
`define ESRC_CLK_MHZ     25
`define ESRC_ESL_US      30
`define ESRC_ESL_CYC     (`ESRC_ESL_US * `ESRC_CLK_MHZ)
`define ESRC_RESUME_NS   200
`define ESRC_RESUME_CYC  ((`ESRC_RESUME_NS * `ESRC_CLK_MHZ) / 1000)
`define ESRC_SE_MS       35
`define ESRC_BE32_MS     150
`define ESRC_BE64_MS     250
`define ESRC_PP_US       600
`endif

// ==== esrc_pkg.sv ====
package esrc_pkg;
   typedef enum logic [1:0] {
      st_idle      = 2'b00,
      st_erase     = 2'b01,
      st_susp_wait = 2'b10,
      st_susp      = 2'b11
   } esrc_state_t;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [23:0] addr;
   } esrc_cmd_t;
endpackage : esrc_pkg

// ==== esrc_host_model.sv ====
`timescale 1ns/1ps
module esrc_host_model (
   input  wire logic mclk,
   output logic      cs_n,
   output logic      sclk,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe_n
);
   logic [7:0] rx_q;

   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
      rx_q = 8'h00;
   end

   // Clock stands low outside frames; 4 mclk a half period gives the 320 ns link clock
   task automatic frame(input logic [39:0] v, input int n);
      int i;
      @(posedge mclk);
      cs_n <= 1'b0;
      rx_q <= 8'h00;
      repeat (4) @(posedge mclk);
      for (i = 0; i < n; i++)
      begin
         si <= v[39 - i];
         repeat (4) @(posedge mclk);
         sclk <= 1'b1;
         if (so_oe_n === 1'b0)
            rx_q <= {rx_q[6:0], so};
         repeat (4) @(posedge mclk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      cs_n <= 1'b1;
      // Released data line shows the inverse so a stale bit is never mistaken for data
      si <= ~si;
      repeat (8) @(posedge mclk);
   endtask : frame
endmodule : esrc_host_model

// ==== erase_suspend_resume_control_tb.sv ====
`timescale 1ns/1ps
`include "esrc_regs.svh"
module erase_suspend_resume_control_tb;
   localparam int unsigned SE_CYC = 3000;
   logic                mclk = 1'b0;
   logic                rst = 1'b1;
   logic                cs_n, sclk, si, so, so_oe_n, cmd_valid, cmd_reject;
   logic                busy_cycle_flag, write_latch_flag, erase_suspended_flag;
   esrc_pkg::esrc_cmd_t cmd;
   logic [7:0]          v;
   int                  fail_count = 0;
   int                  checks_done = 0;
   int                  cyc = 0;
   int                  n_valid = 0;
   int                  n_reject = 0;

   always #20 mclk = ~mclk;

   esrc_ctrl #(.SE_CYC(SE_CYC), .BE32_CYC(4000), .BE64_CYC(5000), .PP_CYC(200)) dut (
      .mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
      .so_oe_n(so_oe_n), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_reject(cmd_reject),
      .busy_cycle_flag(busy_cycle_flag), .write_latch_flag(write_latch_flag),
      .erase_suspended_flag(erase_suspended_flag));

   esrc_host_model host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
      .so_oe_n(so_oe_n));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cmd_valid === 1'b1)
         n_valid <= n_valid + 1;
      if (cmd_reject === 1'b1)
         n_reject <= n_reject + 1;
      if (cyc == 100000)
      begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic chk_bit(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
         fail_count++;
      end
   endtask : chk_bit

   task automatic chk_cmd(input string nm, input esrc_pkg::esrc_cmd_t e,
                          input esrc_pkg::esrc_cmd_t g);
      checks_done++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask : chk_cmd

   task automatic op8(input logic [7:0] o);
      host.frame({o, 32'h0000_0000}, 8);
   endtask : op8

   task automatic op32(input logic [7:0] o, input logic [23:0] a);
      host.frame({o, a, 8'h00}, 32);
   endtask : op32

   task automatic rdsr(input logic [7:0] o);
      host.frame({o, 32'h0000_0000}, 16);
      v = host.rx_q;
   endtask : rdsr

   // Erase, suspend, then watch the latency run out before the flags settle
   task automatic t_erase_suspend(input logic [7:0] o, input logic [23:0] a);
      int k;
      int c0;
      int n0;
      int d;
      op8(`ESRC_OP_WREN);
      chk_bit("wel after wren", 1'b1, write_latch_flag);
      op32(o, a);
      chk_bit("busy in erase", 1'b1, busy_cycle_flag);
      repeat (8) @(posedge mclk);
      op8(`ESRC_OP_SUSPEND);
      // The suspend executed five cycles before the frame task returned
      c0 = cyc;
      n0 = n_valid;
      rdsr(`ESRC_OP_RDSR1);
      chk_bit("sr busy in latency", 1'b1, v[0]);
      rdsr(`ESRC_OP_RDSR3);
      chk_bit("sr3 in latency", 1'b1, v == 8'h00);
      op32(`ESRC_OP_READ, 24'h30_0000);
      chk_bit("read held in latency", 1'b1, n_valid == n0);
      chk_bit("sus in latency", 1'b0, erase_suspended_flag);
      for (k = 0; k < 800 && erase_suspended_flag !== 1'b1; k++)
         @(posedge mclk);
      d = cyc - c0;
      chk_bit("latency length", 1'b1, d > `ESRC_ESL_CYC - 10 && d <= `ESRC_ESL_CYC);
      chk_bit("sus set", 1'b1, erase_suspended_flag);
      chk_bit("wel cleared", 1'b0, write_latch_flag);
      chk_bit("busy idle in suspend", 1'b0, busy_cycle_flag);
      rdsr(`ESRC_OP_RDSR2);
      chk_bit("sr bit 15", 1'b1, v[7]);
   endtask : t_erase_suspend

   task automatic t_access(input logic [7:0] o, input logic [23:0] a, input logic ok);
      int n0;
      int r0;
      n0 = n_valid;
      r0 = n_reject;
      op32(o, a);
      chk_bit("accepted", ok, n_valid == n0 + 1);
      chk_bit("rejected", !ok, n_reject == r0 + 1);
      if (ok)
         chk_cmd("cmd", {o, a}, cmd);
   endtask : t_access

   // Sector 0x012000 is paused; every late-list read into the next sector goes through
   task automatic t_suspended_sector();
      logic [7:0] ops [16] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'he7, 8'h77,
                              8'h90, 8'h92, 8'h94, 8'h9f, 8'h4b, 8'hab, 8'h48, 8'h5a};
      int k;
      foreach (ops[i])
         t_access(ops[i], 24'h01_3000, 1'b1);
      t_access(`ESRC_OP_READ, 24'h01_2fff, 1'b0);
      t_access(8'hc7, 24'h00_0000, 1'b0);
      op8(`ESRC_OP_WREN);
      chk_bit("wren in suspend", 1'b1, write_latch_flag);
      op8(`ESRC_OP_WRDI);
      chk_bit("wrdi in suspend", 1'b0, write_latch_flag);
      op8(`ESRC_OP_WREN);
      host.frame({`ESRC_OP_PP, 24'h01_2100, 8'h5a}, 40);
      chk_bit("pp in region idle", 1'b0, busy_cycle_flag);
      op8(`ESRC_OP_WREN);
      host.frame({`ESRC_OP_QPP, 24'h01_0000, 8'ha5}, 40);
      chk_bit("qpp busy", 1'b1, busy_cycle_flag);
      op8(`ESRC_OP_RESUME);
      chk_bit("resume while busy", 1'b1, erase_suspended_flag);
      for (k = 0; k < 300 && busy_cycle_flag !== 1'b0; k++)
         @(posedge mclk);
      chk_bit("program done", 1'b0, busy_cycle_flag);
      chk_bit("still suspended", 1'b1, erase_suspended_flag);
   endtask : t_suspended_sector

   task automatic t_resume();
      int k;
      op8(`ESRC_OP_RESUME);
      chk_bit("sus after resume", 1'b0, erase_suspended_flag);
      chk_bit("busy after resume", 1'b1, busy_cycle_flag);
      for (k = 0; k < SE_CYC + 100 && busy_cycle_flag !== 1'b0; k++)
         @(posedge mclk);
      chk_bit("erase continues", 1'b1, k > 1000);
      chk_bit("erase done", 1'b0, busy_cycle_flag);
      op8(`ESRC_OP_RESUME);
      chk_bit("resume when idle", 1'b0, busy_cycle_flag);
      op8(`ESRC_OP_SUSPEND);
      repeat (800) @(posedge mclk);
      chk_bit("suspend when idle", 1'b0, erase_suspended_flag);
   endtask : t_resume

   task automatic t_no_program_suspend();
      op8(`ESRC_OP_WREN);
      host.frame({`ESRC_OP_PP, 24'h00_0100, 8'h11}, 40);
      op8(`ESRC_OP_SUSPEND);
      repeat (800) @(posedge mclk);
      chk_bit("program not paused", 1'b0, erase_suspended_flag);
   endtask : t_no_program_suspend

   task automatic t_soft_reset();
      op8(`ESRC_OP_RSTEN);
      op8(`ESRC_OP_RST);
      chk_bit("rst busy", 1'b0, busy_cycle_flag);
      chk_bit("rst sus", 1'b0, erase_suspended_flag);
   endtask : t_soft_reset

   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk_bit("reset busy", 1'b0, busy_cycle_flag);
      chk_bit("reset oe_n", 1'b1, so_oe_n);
      chk_cmd("reset cmd", '0, cmd);
      t_erase_suspend(`ESRC_OP_SE, 24'h01_2345);
      t_suspended_sector();
      t_resume();
      t_no_program_suspend();
      t_erase_suspend(`ESRC_OP_BE32, 24'h02_1234);
      t_access(`ESRC_OP_READ, 24'h02_7ffc, 1'b0);
      t_access(`ESRC_OP_READ, 24'h02_8000, 1'b1);
      t_soft_reset();
      op8(`ESRC_OP_WREN);
      op32(`ESRC_OP_BE64, 24'h05_0000);
      repeat (8) @(posedge mclk);
      op8(`ESRC_OP_SUSPEND);
      t_soft_reset();
      end_of_test();
   end
endmodule : erase_suspend_resume_control_tb
